// *** clu_pkg.sv ***
package clu_pkg;

  // ----------------------------------------
  // Sizes and register indices
  // ----------------------------------------
  localparam int         CLU_TABLES   = 4;
  localparam int         CLU_ADDR_W   = 8;
  localparam logic [7:0] IDX_CTRL     = 8'h00;
  localparam logic [7:0] IDX_SEQ0     = 8'h04;
  localparam logic [7:0] IDX_SEQ1     = 8'h05;
  localparam logic [7:0] IDX_LUT0     = 8'h08;
  localparam logic [7:0] IDX_LUT1     = 8'h0c;
  localparam logic [7:0] IDX_LUT2     = 8'h10;
  localparam logic [7:0] IDX_LUT3     = 8'h14;

  // ----------------------------------------
  // Field positions and write masks
  // ----------------------------------------
  localparam int          CTRL_SOFT   = 0;
  localparam int          CTRL_EN     = 1;
  localparam int          CTRL_KEEP   = 6;
  localparam int          LUT_EN      = 1;
  localparam int          LUT_FILT_LO = 4;
  localparam int          LUT_EDGE    = 7;
  localparam int          LUT_INS_LO  = 8;
  localparam int          LUT_EVINV   = 20;
  localparam int          LUT_EVIN    = 21;
  localparam int          LUT_EVOUT   = 22;
  localparam int          LUT_TRUTH_LO = 24;
  localparam logic [31:0] LUT_WMASK   = 32'hff7f_ffb2;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [31:0] LUT_RST     = 32'h0000_0000;

  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [3:0] SEQ_NONE  = 4'h0;
  localparam logic [3:0] SEQ_DFF   = 4'h1;
  localparam logic [3:0] SEQ_JK    = 4'h2;
  localparam logic [3:0] SEQ_LATCH = 4'h3;
  localparam logic [3:0] SEQ_RS    = 4'h4;
  localparam logic [3:0] SRC_MASK  = 4'h0;
  localparam logic [3:0] SRC_FB    = 4'h1;
  localparam logic [3:0] SRC_LINK  = 4'h2;
  localparam logic [3:0] SRC_EVENT = 4'h3;
  localparam logic [3:0] SRC_IO    = 4'h4;
  localparam logic [3:0] SRC_CMP   = 4'h5;
  localparam logic [3:0] SRC_TMR   = 4'h6;
  localparam logic [3:0] SRC_ATMR  = 4'h7;
  localparam logic [3:0] SRC_CTMR  = 4'h8;
  localparam logic [3:0] SRC_SER   = 4'h9;
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_SYNC = 2'h1;
  localparam logic [1:0] FILT_DIG  = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } clu_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } clu_axi_rsp_t;

  typedef struct packed {
    logic [3:0]      event_in;
    logic [3:0][2:0] io_in;
    logic [1:0]      cmp_in;
    logic [4:0]      timer_in;
    logic [2:0][2:0] ctimer_in;
    logic [3:0]      serial_tx_in;
  } clu_src_t;

  typedef struct packed {
    logic            keep;
    logic            en;
    logic [1:0][3:0] seq;
    logic [3:0][31:0] lut;
  } clu_cfg_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] s4;
    logic [3:0] filt;
    logic [3:0] edge_d;
    logic [3:0] out;
    logic [3:0] evo;
    logic [1:0] seq_q;
  } clu_dp_t;

  typedef struct packed {
    logic                  aw_v;
    logic [CLU_ADDR_W-1:0] aw_addr;
    logic                  w_v;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } clu_bus_t;

  typedef struct packed {
    clu_cfg_t cfg;
    clu_dp_t  dp;
    logic     soft_busy;
    clu_bus_t bus;
  } clu_state_t;

endpackage

// *** clu_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module clu_top #(
  parameter int TABLES = clu_pkg::CLU_TABLES
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              standby_sleep,
  input  wire clu_pkg::clu_axi_req_t axi_req,
  output clu_pkg::clu_axi_rsp_t  axi_rsp,
  input  wire clu_pkg::clu_src_t src,
  output logic [3:0]             table_out,
  output logic [3:0]             event_out
);
  import clu_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (TABLES != 4) begin : g_chk
    $error("Only four tables are supported");
  end

  clu_state_t st_reg;
  clu_state_t st_next;

  logic [3:0]      act;
  logic [3:0][2:0] in_bit;
  logic [3:0]      raw;
  logic [3:0]      ev;

  // ----------------------------------------
  // Input selection and truth lookup
  // ----------------------------------------
  function automatic logic pick(input logic [3:0] code, input int t, input int x, input clu_src_t s,
                                input logic fb, input logic lk, input logic e);
    logic r;
    r = 1'b0;
    case (code)
      SRC_FB:    r = fb;
      SRC_LINK:  r = lk;
      SRC_EVENT: r = e;
      SRC_IO:    r = s.io_in[t][x];
      SRC_CMP:   r = (t < 2) ? s.cmp_in[t] : 1'b0;
      SRC_TMR:   r = s.timer_in[t];
      SRC_ATMR:  r = s.timer_in[t+1];
      SRC_CTMR:  r = (t < 3) ? s.ctimer_in[t][x] : 1'b0;
      SRC_SER:   r = s.serial_tx_in[t];
      default:   r = 1'b0;
    endcase
    return r;
  endfunction

  for (genvar t = 0; t < 4; t++) begin : g_tab
    logic [31:0] c;
    assign c = st_reg.cfg.lut[t];
    assign act[t] = st_reg.cfg.en & c[LUT_EN];
    assign ev[t] = c[LUT_EVIN] & (src.event_in[t] ^ c[LUT_EVINV]);
    for (genvar x = 0; x < 3; x++) begin : g_in
      assign in_bit[t][x] = pick(c[LUT_INS_LO+4*x +: 4], t, x, src, st_reg.dp.out[t],
                                 st_reg.dp.out[(t+1)%4], ev[t]);
    end
    assign raw[t] = act[t] & c[LUT_TRUTH_LO + in_bit[t]];
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic        aw_fire;
  logic        w_fire;
  logic        ar_fire;
  logic        wr_go;
  logic [7:0]  wa;
  logic [7:0]  ra;
  logic [31:0] rd_val;
  logic        rd_ok;

  assign axi_rsp.awready = ce & ~st_reg.bus.aw_v;
  assign axi_rsp.wready  = ce & ~st_reg.bus.w_v;
  assign axi_rsp.arready = ce & ~st_reg.bus.rvalid;
  assign axi_rsp.bvalid  = st_reg.bus.bvalid;
  assign axi_rsp.bresp   = st_reg.bus.bresp;
  assign axi_rsp.rvalid  = st_reg.bus.rvalid;
  assign axi_rsp.rdata   = st_reg.bus.rdata;
  assign axi_rsp.rresp   = st_reg.bus.rresp;
  assign aw_fire = axi_req.awvalid & axi_rsp.awready;
  assign w_fire  = axi_req.wvalid & axi_rsp.wready;
  assign ar_fire = axi_req.arvalid & axi_rsp.arready;
  assign wr_go   = ce & st_reg.bus.aw_v & st_reg.bus.w_v & ~st_reg.bus.bvalid;
  assign wa      = st_reg.bus.aw_addr;
  assign ra      = axi_req.araddr[7:0];

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    case (ra)
      {IDX_CTRL[5:0], 2'b00}: begin
        rd_val[CTRL_SOFT]  = st_reg.soft_busy;
        rd_val[CTRL_EN]    = st_reg.cfg.en;
        rd_val[CTRL_KEEP]  = st_reg.cfg.keep;
      end
      {IDX_SEQ0[5:0], 2'b00}: rd_val[3:0] = st_reg.cfg.seq[0];
      {IDX_SEQ1[5:0], 2'b00}: rd_val[3:0] = st_reg.cfg.seq[1];
      {IDX_LUT0[5:0], 2'b00}: rd_val = st_reg.cfg.lut[0];
      {IDX_LUT1[5:0], 2'b00}: rd_val = st_reg.cfg.lut[1];
      {IDX_LUT2[5:0], 2'b00}: rd_val = st_reg.cfg.lut[2];
      {IDX_LUT3[5:0], 2'b00}: rd_val = st_reg.cfg.lut[3];
      default:                rd_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [3:0]  pre;
    logic [3:0]  fin;
    logic [3:0]  seq_used;
    logic [31:0] m;
    logic        a;
    logic        b;
    logic        q;
    logic        so;
    logic        qn;
    logic        ok;
    pre      = 4'h0;
    fin      = 4'h0;
    seq_used = 4'h0;
    m        = 32'h0000_0000;
    a        = 1'b0;
    b        = 1'b0;
    q        = 1'b0;
    so       = 1'b0;
    qn       = 1'b0;
    ok       = 1'b1;
    st_next  = st_reg;
    if (ce) begin
      // Filter, synchroniser and edge detector
      for (int t = 0; t < 4; t++) begin
        st_next.dp.s1[t] = raw[t];
        st_next.dp.s2[t] = st_reg.dp.s1[t];
        st_next.dp.s3[t] = st_reg.dp.s2[t];
        st_next.dp.s4[t] = st_reg.dp.s3[t];
        if (st_reg.dp.s2[t] & st_reg.dp.s3[t] & st_reg.dp.s4[t]) begin
          st_next.dp.filt[t] = 1'b1;
        end else if (~(st_reg.dp.s2[t] | st_reg.dp.s3[t] | st_reg.dp.s4[t])) begin
          st_next.dp.filt[t] = 1'b0;
        end
        case (st_reg.cfg.lut[t][LUT_FILT_LO +: 2])
          FILT_NONE: pre[t] = raw[t];
          FILT_SYNC: pre[t] = st_reg.dp.s2[t];
          FILT_DIG:  pre[t] = st_reg.dp.filt[t];
          default:   pre[t] = raw[t];
        endcase
        st_next.dp.edge_d[t] = pre[t];
        if (st_reg.cfg.lut[t][LUT_EDGE]) begin
          pre[t] = pre[t] & ~st_reg.dp.edge_d[t];
        end
        if (!act[t]) begin
          st_next.dp.s1[t]     = 1'b0;
          st_next.dp.s2[t]     = 1'b0;
          st_next.dp.s3[t]     = 1'b0;
          st_next.dp.s4[t]     = 1'b0;
          st_next.dp.filt[t]   = 1'b0;
          st_next.dp.edge_d[t] = 1'b0;
        end
      end
      fin = pre;
      // Sequential element per table pair
      for (int p = 0; p < 2; p++) begin
        a  = pre[2*p];
        b  = pre[2*p+1];
        q  = st_reg.dp.seq_q[p];
        so = a;
        qn = 1'b0;
        seq_used[2*p]   = 1'b1;
        seq_used[2*p+1] = 1'b1;
        case (st_reg.cfg.seq[p])
          SEQ_DFF: begin
            qn = b ? a : q;
            so = q;
          end
          SEQ_JK: begin
            qn = (a & b) ? ~q : (a ? 1'b1 : (b ? 1'b0 : q));
            so = q;
          end
          SEQ_LATCH: begin
            qn = b ? a : q;
            so = qn;
          end
          SEQ_RS: begin
            qn = a ? 1'b1 : (b ? 1'b0 : q);
            so = qn;
          end
          default: begin
            seq_used[2*p]   = 1'b0;
            seq_used[2*p+1] = 1'b0;
          end
        endcase
        if (!act[2*p]) begin
          qn = 1'b0;
          so = 1'b0;
        end
        st_next.dp.seq_q[p] = qn;
        fin[2*p] = so;
      end
      // Standby gating and output events
      for (int t = 0; t < 4; t++) begin
        if (standby_sleep && !st_reg.cfg.keep && (seq_used[t] || st_reg.cfg.lut[t][LUT_EDGE] ||
            st_reg.cfg.lut[t][LUT_FILT_LO +: 2] != FILT_NONE)) begin
          fin[t] = 1'b0;
        end
      end
      st_next.dp.out = fin;
      for (int t = 0; t < 4; t++) begin
        st_next.dp.evo[t] = fin[t] & st_reg.cfg.lut[t][LUT_EVOUT];
      end

      // Bus channels
      if (aw_fire) begin
        st_next.bus.aw_v    = 1'b1;
        st_next.bus.aw_addr = axi_req.awaddr[7:0];
      end
      if (w_fire) begin
        st_next.bus.w_v   = 1'b1;
        st_next.bus.wdata = axi_req.wdata;
        st_next.bus.wstrb = axi_req.wstrb;
      end
      if (st_reg.bus.bvalid && axi_req.bready) begin
        st_next.bus.bvalid = 1'b0;
      end
      if (st_reg.bus.rvalid && axi_req.rready) begin
        st_next.bus.rvalid = 1'b0;
      end
      if (ar_fire) begin
        st_next.bus.rvalid = 1'b1;
        st_next.bus.rdata  = rd_val;
        st_next.bus.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (wr_go) begin
        st_next.bus.aw_v   = 1'b0;
        st_next.bus.w_v    = 1'b0;
        st_next.bus.bvalid = 1'b1;
        for (int k = 0; k < 4; k++) begin
          m[8*k +: 8] = {8{st_reg.bus.wstrb[k]}};
        end
        m = m & LUT_WMASK;
        case (wa)
          {IDX_CTRL[5:0], 2'b00}: begin
            if (st_reg.bus.wstrb[0]) begin
              st_next.cfg.en = st_reg.bus.wdata[CTRL_EN];
              if (!st_reg.cfg.en) begin
                st_next.cfg.keep = st_reg.bus.wdata[CTRL_KEEP];
              end
              if (st_reg.bus.wdata[CTRL_SOFT]) begin
                st_next.soft_busy = 1'b1;
              end
            end
          end
          {IDX_SEQ0[5:0], 2'b00}, {IDX_SEQ1[5:0], 2'b00}: begin
            if (!st_reg.cfg.en && st_reg.bus.wstrb[0]) begin
              st_next.cfg.seq[wa[2]] = st_reg.bus.wdata[3:0];
            end
          end
          {IDX_LUT0[5:0], 2'b00}, {IDX_LUT1[5:0], 2'b00},
          {IDX_LUT2[5:0], 2'b00}, {IDX_LUT3[5:0], 2'b00}: begin
            if (!st_reg.cfg.en) begin
              st_next.cfg.lut[wa[5:4]-2'd2] = (st_reg.cfg.lut[wa[5:4]-2'd2] & ~m) |
                                             (st_reg.bus.wdata & m);
            end
          end
          default: ok = 1'b0;
        endcase
        st_next.bus.bresp = ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (st_reg.soft_busy) begin
        st_next.cfg       = '0;
        st_next.dp        = '0;
        st_next.soft_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign table_out = st_reg.dp.out;
  assign event_out = st_reg.dp.evo;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic ctrl_wr;
  logic seq_wr;
  logic lut0_wr;
  assign ctrl_wr = wr_go && wa == {IDX_CTRL[5:0], 2'b00} && st_reg.bus.wstrb[0];
  assign seq_wr  = wr_go && wa == {IDX_SEQ0[5:0], 2'b00} && st_reg.bus.wstrb[0];
  assign lut0_wr = wr_go && wa == {IDX_LUT0[5:0], 2'b00};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  AST_SOFT_CLEARS: assert property (ctrl_wr && st_reg.bus.wdata[CTRL_SOFT] |=>
    st_reg.soft_busy ##1 (st_reg.cfg == '0))
    else $error("soft reset did not clear configuration");
  AST_SOFT_READS_BUSY: assert property (ar_fire && ra == {IDX_CTRL[5:0], 2'b00}
    |=> st_reg.bus.rdata[CTRL_SOFT] == $past(st_reg.soft_busy))
    else $error("reset status bit read wrong");
  AST_CTRL_PROTECT: assert property (ctrl_wr && st_reg.cfg.en && !st_reg.soft_busy
    |=> st_reg.cfg.keep == $past(st_reg.cfg.keep))
    else $error("standby keep bit changed while enabled");
  AST_SEQ_PROTECT: assert property (seq_wr && st_reg.cfg.en && !st_reg.soft_busy
    |=> $stable(st_reg.cfg.seq))
    else $error("sequential mode written while enabled");
  AST_LUT_PROTECT: assert property (lut0_wr && st_reg.cfg.en && !st_reg.soft_busy
    |=> $stable(st_reg.cfg.lut))
    else $error("table control written while enabled");
  AST_ENABLE_WRITE: assert property (ctrl_wr && !st_reg.soft_busy
    |=> st_reg.cfg.en == $past(st_reg.bus.wdata[CTRL_EN]))
    else $error("enable bit not taken");
  AST_EVENT_GATE: assert property (event_out[0] |-> $past(st_reg.cfg.lut[0][LUT_EVOUT])
    && table_out[0])
    else $error("event out without enable");
  AST_TRUTH_PATH: assert property (ce && act[0] && !st_reg.soft_busy &&
    st_reg.cfg.lut[0][LUT_FILT_LO +: 2] == FILT_NONE && !st_reg.cfg.lut[0][LUT_EDGE] &&
    st_reg.cfg.seq[0] == SEQ_NONE |=> table_out[0] == $past(st_reg.cfg.lut[0][LUT_TRUTH_LO + in_bit[0]]))
    else $error("table output not truth bit");
  AST_FILTER_CLEAR: assert property (ce && !act[0] |=> st_reg.dp.s1[0] == 1'b0
    && st_reg.dp.filt[0] == 1'b0 && st_reg.dp.edge_d[0] == 1'b0)
    else $error("filter state not cleared");
  AST_SEQ_CLEAR: assert property (ce && !act[0] |=> st_reg.dp.seq_q[0] == 1'b0)
    else $error("pair element not cleared");
  AST_STANDBY_ZERO: assert property (ce && standby_sleep && !st_reg.cfg.keep &&
    st_reg.cfg.lut[0][LUT_FILT_LO +: 2] == FILT_SYNC |=> table_out[0] == 1'b0)
    else $error("output not forced in standby");

  COV_WRITE: cover property (wr_go ##[1:4] axi_rsp.bvalid && axi_req.bready);
  COV_READ: cover property (ar_fire ##1 axi_rsp.rvalid && axi_req.rready);
  COV_SOFT: cover property (st_reg.soft_busy ##1 !st_reg.soft_busy);
  COV_JK: cover property (st_reg.cfg.seq[0] == SEQ_JK && act[0] && pre_toggle());

  function automatic logic pre_toggle();
    return st_reg.dp.seq_q[0] != st_next.dp.seq_q[0];
  endfunction

endmodule
`default_nettype wire

// *** clu_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module clu_top_tb;
  import clu_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic         clk;
  logic         resetn;
  logic         ce;
  logic         standby_sleep;
  clu_axi_req_t req;
  clu_axi_rsp_t rsp;
  clu_src_t     src;
  clu_src_t     s;
  logic [3:0]   table_out;
  logic [3:0]   event_out;
  int           fail_count;
  int           samples_checked;
  int           i;
  logic [7:0]   tt;
  logic [7:0]   regs [7];
  logic [2:0]   evc [3];
  logic         eve [3];

  localparam logic [4:0] DFF_D = 5'b01001;
  localparam logic [4:0] DFF_G = 5'b01101;
  localparam logic [4:0] DFF_Q = 5'b11011;

  clu_top i_clu_top (
    .clk           (clk),
    .resetn        (resetn),
    .ce            (ce),
    .standby_sleep (standby_sleep),
    .axi_req       (req),
    .axi_rsp       (rsp),
    .src           (src),
    .table_out     (table_out),
    .event_out     (event_out)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic mismatch(input string m);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) mismatch($sformatf("read %h expected %h", got, exp));
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) mismatch($sformatf("resp %h expected %h", got, exp));
  endtask

  task automatic chk_out(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) mismatch($sformatf("output %b expected %b", got, exp));
  endtask

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic       aw;
    logic       w;
    logic       b;
    logic [1:0] r;
    int         n;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= {22'h0, idx, 2'b00};
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge clk);
      aw = req.awvalid & rsp.awready;
      w = req.wvalid & rsp.wready;
      b = req.bready & rsp.bvalid;
      r = rsp.bresp;
      @(posedge clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) begin
        req.bready <= 1'b0;
        break;
      end
    end
    if (n == 64) begin
      mismatch("write timed out");
      conclude();
    end
    chk_resp(r, er);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic        ar;
    logic        b;
    logic [1:0]  r;
    logic [31:0] d;
    int          n;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr  <= {22'h0, idx, 2'b00};
    req.rready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge clk);
      ar = req.arvalid & rsp.arready;
      b = req.rready & rsp.rvalid;
      r = rsp.rresp;
      d = rsp.rdata;
      @(posedge clk);
      if (ar) req.arvalid <= 1'b0;
      if (b) begin
        req.rready <= 1'b0;
        break;
      end
    end
    if (n == 64) begin
      mismatch("read timed out");
      conclude();
    end
    chk_resp(r, er);
    chk_reg(d, exp);
  endtask

  // ----------------------------------------
  // Table helpers
  // ----------------------------------------
  function automatic logic [31:0] lut_word(logic [7:0] t, logic [2:0] ev, logic [3:0] s0,
                                           logic [3:0] s1, logic [1:0] f);
    return {t, 1'b0, ev, SRC_MASK, s1, s0, 2'b00, f, 4'b0010};
  endfunction

  task automatic cfg0(input logic [31:0] word);
    wr(IDX_CTRL, 32'h0, RESP_OKAY);
    wr(IDX_LUT0, word, RESP_OKAY);
    wr(IDX_CTRL, 32'h2, RESP_OKAY);
  endtask

  task automatic put(input clu_src_t v);
    @(posedge clk);
    src <= v;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    standby_sleep = 1'b0;
    req = '0;
    src = '0;
    fail_count = 0;
    samples_checked = 0;
    regs = '{IDX_CTRL, IDX_SEQ0, IDX_SEQ1, IDX_LUT0, IDX_LUT1, IDX_LUT2, IDX_LUT3};
    evc = '{3'b010, 3'b011, 3'b000};
    eve = '{1'b1, 1'b0, 1'b0};
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 7; i++) rd(regs[i], 32'h0, RESP_OKAY);
    rd(8'h02, 32'h0, RESP_SLVERR);
    wr(8'h02, 32'hffff_ffff, RESP_SLVERR);
    for (i = 3; i < 7; i++) begin
      wr(regs[i], 32'hffff_ffff, RESP_OKAY);
      rd(regs[i], LUT_WMASK, RESP_OKAY);
    end
    for (i = 0; i < 5; i++) begin
      wr(IDX_SEQ0, 32'(i), RESP_OKAY);
      wr(IDX_SEQ1, 32'(4 - i), RESP_OKAY);
      rd(IDX_SEQ0, 32'(i), RESP_OKAY);
      rd(IDX_SEQ1, 32'(4 - i), RESP_OKAY);
    end
    wr(IDX_CTRL, 32'h40, RESP_OKAY);
    rd(IDX_CTRL, 32'h40, RESP_OKAY);
    wr(IDX_CTRL, 32'h42, RESP_OKAY);
    rd(IDX_CTRL, 32'h42, RESP_OKAY);
    wr(IDX_CTRL, 32'h02, RESP_OKAY);
    rd(IDX_CTRL, 32'h42, RESP_OKAY);
    wr(IDX_LUT0, 32'h0, RESP_OKAY);
    rd(IDX_LUT0, LUT_WMASK, RESP_OKAY);
    wr(IDX_SEQ0, 32'h1, RESP_OKAY);
    rd(IDX_SEQ0, 32'h4, RESP_OKAY);
    wr(IDX_CTRL, 32'h43, RESP_OKAY);
    for (i = 0; i < 7; i++) rd(regs[i], 32'h0, RESP_OKAY);
    // Truth lookup over all input values
    tt = 8'hb4;
    cfg0(lut_word(tt, 3'b100, SRC_IO, SRC_IO, FILT_NONE) | 32'h0004_0000);
    for (i = 0; i < 8; i++) begin
      s = '0;
      s.io_in[0] = i[2:0];
      put(s);
      settle(3);
      chk_out(table_out[0], tt[i]);
      chk_out(event_out[0], tt[i]);
    end
    cfg0(lut_word(8'hff, 3'b000, SRC_MASK, SRC_MASK, FILT_NONE));
    settle(3);
    chk_out(table_out[0], 1'b1);
    chk_out(event_out[0], 1'b0);
    cfg0(lut_word(8'hff, 3'b000, SRC_MASK, SRC_MASK, FILT_NONE) & ~32'h2);
    settle(3);
    chk_out(table_out[0], 1'b0);
    // Event input enable and inversion
    s = '0;
    s.event_in[0] = 1'b1;
    put(s);
    for (i = 0; i < 3; i++) begin
      cfg0(lut_word(8'haa, evc[i], SRC_EVENT, SRC_MASK, FILT_NONE));
      settle(3);
      chk_out(table_out[0], eve[i]);
    end
    // Peripheral source codes and a reserved one
    for (i = 0; i < 6; i++) begin
      s = '0;
      case (i)
        0: s.cmp_in[0] = 1'b1;
        1: s.timer_in[0] = 1'b1;
        2: s.timer_in[1] = 1'b1;
        3: s.ctimer_in[0][0] = 1'b1;
        4: s.serial_tx_in[0] = 1'b1;
        default: s = '1;
      endcase
      put(s);
      cfg0(lut_word(8'haa, 3'b000, 4'(5 + i), SRC_MASK, FILT_NONE));
      settle(3);
      chk_out(table_out[0], i < 5);
    end
    // Synchroniser delay and standby forcing
    put('0);
    cfg0(lut_word(8'haa, 3'b000, SRC_IO, SRC_MASK, FILT_SYNC));
    settle(8);
    s = '0;
    s.io_in[0] = 3'b001;
    put(s);
    settle(1);
    chk_out(table_out[0], 1'b0);
    settle(8);
    chk_out(table_out[0], 1'b1);
    @(posedge clk);
    standby_sleep <= 1'b1;
    settle(3);
    chk_out(table_out[0], 1'b0);
    @(posedge clk);
    standby_sleep <= 1'b0;
    cfg0(lut_word(8'haa, 3'b000, SRC_IO, SRC_MASK, FILT_DIG));
    settle(12);
    chk_out(table_out[0], 1'b1);
    // Rising edge pulse after the synchroniser
    put('0);
    cfg0(lut_word(8'haa, 3'b000, SRC_IO, SRC_MASK, FILT_SYNC) | 32'h0000_0080);
    settle(8);
    put(s);
    settle(3);
    chk_out(table_out[0], 1'b1);
    settle(1);
    chk_out(table_out[0], 1'b0);
    // D flip-flop on pair 0, clear on disable, clock enable freeze
    wr(IDX_CTRL, 32'h0, RESP_OKAY);
    wr(IDX_SEQ0, 32'(SEQ_DFF), RESP_OKAY);
    wr(IDX_LUT1, lut_word(8'haa, 3'b000, SRC_IO, SRC_MASK, FILT_NONE), RESP_OKAY);
    cfg0(lut_word(8'haa, 3'b000, SRC_IO, SRC_MASK, FILT_NONE));
    for (i = 0; i < 5; i++) begin
      s = '0;
      s.io_in[0][0] = DFF_D[i];
      s.io_in[1][0] = DFF_G[i];
      put(s);
      settle(3);
      chk_out(table_out[0], DFF_Q[i]);
      chk_out(table_out[1], DFF_G[i]);
    end
    wr(IDX_CTRL, 32'h0, RESP_OKAY);
    wr(IDX_CTRL, 32'h2, RESP_OKAY);
    settle(3);
    chk_out(table_out[0], 1'b0);
    @(posedge clk);
    ce <= 1'b0;
    s.io_in[0][0] = 1'b1;
    s.io_in[1][0] = 1'b1;
    put(s);
    settle(3);
    chk_out(table_out[0], 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    settle(3);
    chk_out(table_out[0], 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
